/* rtl/bpb_pin_drv.sv */
`timescale 1ns/1ns
`include "bpb_regs.svh"
module bpb_pin_drv #(
	parameter bpb_pkg::bpb_byte_t DIR_MASK = 8'hff
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire bpb_pkg::bpb_byte_t dir,
	input wire bpb_pkg::bpb_byte_t latch,
	input wire bpb_pkg::bpb_byte_t periph_sel,
	input wire bpb_pkg::bpb_byte_t periph_val,
	output bpb_pkg::bpb_byte_t pin_out,
	output bpb_pkg::bpb_byte_t pin_oe
);
	import bpb_pkg::*;

	genvar b;
	generate
		for (b = 0; b < 8; b = b + 1) begin : g_bit
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pin_out[b] <= `BPB_PIN_IDLE;
					pin_oe[b] <= `BPB_PIN_IDLE;
				end else begin
					// Masked bits (no pin, input only) stay undriven
					pin_oe[b] <= DIR_MASK[b] & (periph_sel[b] | dir[b]);
					pin_out[b] <= periph_sel[b] ? periph_val[b] : latch[b];
				end
			end
		end
	endgenerate
endmodule // bpb_pin_drv

/* rtl/bpb_pkg.sv */
package bpb_pkg;
	typedef logic [7:0] bpb_byte_t;
	typedef enum logic [0:0] {
		BPB_BUS_IDLE,
		BPB_BUS_READ
	} bpb_bus_e;
endpackage

/* rtl/bpb_port.sv */
`timescale 1ns/1ns
`include "bpb_regs.svh"
module bpb_port #(
	parameter bpb_pkg::bpb_byte_t DATA_MASK = 8'hff,
	parameter bpb_pkg::bpb_byte_t DIR_MASK = 8'hff
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire bpb_pkg::bpb_byte_t wr_data,
	input wire logic wr_latch,
	input wire logic wr_dir,
	input wire bpb_pkg::bpb_byte_t pin_level,
	output bpb_pkg::bpb_byte_t dir,
	output bpb_pkg::bpb_byte_t latch,
	output bpb_pkg::bpb_byte_t data_rd
);
	import bpb_pkg::*;

	// Unimplemented bits never store a one, so they read back as zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir <= `BPB_DIR_RESET;
		end else if (wr_dir) begin
			dir <= wr_data & DIR_MASK;
		end
	end

	// Direction writes leave the latch alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch <= `BPB_LATCH_RESET;
		end else if (wr_latch) begin
			latch <= wr_data & DATA_MASK;
		end
	end

	assign data_rd = ((dir & latch) | (~dir & pin_level)) & DATA_MASK;
endmodule // bpb_port

/* rtl/bpb_regs.svh */
`ifndef BPB_REGS_SVH
`define BPB_REGS_SVH

`define BPB_NPORTS 5
`define BPB_NPINS 40
`define BPB_IDX_W 10
`define BPB_IDX_LSB 2
`define BPB_IDX_MSB 11

// Register indices; byte address is four times the index
`define BPB_IDX_P2_DATA 10'h0e4
`define BPB_IDX_P2_DIR 10'h0e6
`define BPB_IDX_P5_DATA 10'h0e9
`define BPB_IDX_P5_DIR 10'h0eb
`define BPB_IDX_P7_DATA 10'h0ed
`define BPB_IDX_P7_DIR 10'h0ef
`define BPB_IDX_P8_DATA 10'h0f0
`define BPB_IDX_P9_DATA 10'h0f1
`define BPB_IDX_P8_DIR 10'h0f2
`define BPB_IDX_P9_DIR 10'h0f3

// Implemented data bits and drivable direction bits per port
`define BPB_DMASK_P2 8'hff
`define BPB_DMASK_P5 8'h7f
`define BPB_DMASK_P7 8'h02
`define BPB_DMASK_P8 8'hff
`define BPB_DMASK_P9 8'h03
`define BPB_DIRMASK_P5 8'h5f

`define BPB_DIR_RESET 8'h00
`define BPB_LATCH_RESET 8'h00
`define BPB_PIN_IDLE 1'b0
`define BPB_BYTE_ZERO 8'h00
`define BPB_RDATA_PAD 24'h00_0000
`define BPB_RDATA_RESET 32'h0000_0000
`define BPB_HRESP_OKAY 1'b0
`define BPB_HTRANS_ACTIVE_BIT 1

`endif

/* rtl/bpb_top.sv */
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ns
`include "bpb_regs.svh"
module bpb_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [39:0] pin_in,
	output logic [39:0] pin_out,
	output logic [39:0] pin_oe,
	input wire logic [39:0] periph_out_sel,
	input wire logic [39:0] periph_out
);
	import bpb_pkg::*;

	localparam bpb_byte_t DMASK [`BPB_NPORTS] = '{
		`BPB_DMASK_P2, `BPB_DMASK_P5, `BPB_DMASK_P7, `BPB_DMASK_P8, `BPB_DMASK_P9
	};
	localparam bpb_byte_t DIRMASK [`BPB_NPORTS] = '{
		`BPB_DMASK_P2, `BPB_DIRMASK_P5, `BPB_DMASK_P7, `BPB_DMASK_P8, `BPB_DMASK_P9
	};

	logic accept;
	logic wr_pend;
	logic [`BPB_IDX_W-1:0] cap_idx;
	bpb_bus_e bus_state;
	bpb_byte_t rd_byte;
	logic [`BPB_NPORTS-1:0] wr_latch;
	logic [`BPB_NPORTS-1:0] wr_dir;
	bpb_byte_t port_dir [`BPB_NPORTS];
	bpb_byte_t port_latch [`BPB_NPORTS];
	bpb_byte_t port_rd [`BPB_NPORTS];
	logic [2:0] size_unused;

	// Only word transfers are used; size does not change the access
	assign size_unused = hsize;

	assign accept = hsel && htrans[`BPB_HTRANS_ACTIVE_BIT] && hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_idx <= '0;
		end else if (accept) begin
			cap_idx <= haddr[`BPB_IDX_MSB:`BPB_IDX_LSB];
		end
	end

	// Writes commit at the end of their data phase with no wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
		end else begin
			wr_pend <= accept && hwrite;
		end
	end

	// Reads take one wait state so a write just before them is seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_state <= BPB_BUS_IDLE;
			hreadyout <= 1'b1;
		end else begin
			case (bus_state)
				BPB_BUS_IDLE: begin
					if (accept && !hwrite) begin
						bus_state <= BPB_BUS_READ;
						hreadyout <= 1'b0;
					end
				end
				BPB_BUS_READ: begin
					bus_state <= BPB_BUS_IDLE;
					hreadyout <= 1'b1;
				end
				default: begin
					bus_state <= BPB_BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= `BPB_RDATA_RESET;
		end else if (bus_state == BPB_BUS_READ) begin
			hrdata <= {`BPB_RDATA_PAD, rd_byte};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= `BPB_HRESP_OKAY;
		end else begin
			hresp <= `BPB_HRESP_OKAY;
		end
	end

	// Unmapped indices read zero and ignore writes
	always_comb begin
		rd_byte = `BPB_BYTE_ZERO;
		case (cap_idx)
			`BPB_IDX_P2_DATA: rd_byte = port_rd[0];
			`BPB_IDX_P2_DIR: rd_byte = port_dir[0];
			`BPB_IDX_P5_DATA: rd_byte = port_rd[1];
			`BPB_IDX_P5_DIR: rd_byte = port_dir[1];
			`BPB_IDX_P7_DATA: rd_byte = port_rd[2];
			`BPB_IDX_P7_DIR: rd_byte = port_dir[2];
			`BPB_IDX_P8_DATA: rd_byte = port_rd[3];
			`BPB_IDX_P8_DIR: rd_byte = port_dir[3];
			`BPB_IDX_P9_DATA: rd_byte = port_rd[4];
			`BPB_IDX_P9_DIR: rd_byte = port_dir[4];
			default: rd_byte = `BPB_BYTE_ZERO;
		endcase
	end

	always_comb begin
		wr_latch = '0;
		wr_dir = '0;
		if (wr_pend) begin
			case (cap_idx)
				`BPB_IDX_P2_DATA: wr_latch[0] = 1'b1;
				`BPB_IDX_P2_DIR: wr_dir[0] = 1'b1;
				`BPB_IDX_P5_DATA: wr_latch[1] = 1'b1;
				`BPB_IDX_P5_DIR: wr_dir[1] = 1'b1;
				`BPB_IDX_P7_DATA: wr_latch[2] = 1'b1;
				`BPB_IDX_P7_DIR: wr_dir[2] = 1'b1;
				`BPB_IDX_P8_DATA: wr_latch[3] = 1'b1;
				`BPB_IDX_P8_DIR: wr_dir[3] = 1'b1;
				`BPB_IDX_P9_DATA: wr_latch[4] = 1'b1;
				`BPB_IDX_P9_DIR: wr_dir[4] = 1'b1;
				default: begin
					wr_latch = '0;
					wr_dir = '0;
				end
			endcase
		end
	end

	genvar p;
	generate
		for (p = 0; p < `BPB_NPORTS; p = p + 1) begin : g_port
			bpb_port #(
				.DATA_MASK(DMASK[p]),
				.DIR_MASK(DIRMASK[p])
			) u_port (
				.hclk(hclk),
				.hresetn(hresetn),
				.wr_data(hwdata[7:0]),
				.wr_latch(wr_latch[p]),
				.wr_dir(wr_dir[p]),
				.pin_level(pin_in[p*8 +: 8]),
				.dir(port_dir[p]),
				.latch(port_latch[p]),
				.data_rd(port_rd[p])
			);
			bpb_pin_drv #(
				.DIR_MASK(DIRMASK[p] & DMASK[p])
			) u_drv (
				.hclk(hclk),
				.hresetn(hresetn),
				.dir(port_dir[p]),
				.latch(port_latch[p]),
				.periph_sel(periph_out_sel[p*8 +: 8]),
				.periph_val(periph_out[p*8 +: 8]),
				.pin_out(pin_out[p*8 +: 8]),
				.pin_oe(pin_oe[p*8 +: 8])
			);
		end
	endgenerate
endmodule // bpb_top

/* test/bpb_pin_env.sv */
`timescale 1ns/1ns
module bpb_pin_env (
	input wire logic [39:0] pin_out,
	input wire logic [39:0] pin_oe,
	input wire logic [39:0] ext,
	output logic [39:0] pin_in
);
	// Driven pins read back their own level, the rest follow the outside circuit
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // bpb_pin_env

/* test/bpb_top_asserts.sv */
`timescale 1ns/1ns
`include "bpb_regs.svh"
module bpb_top_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [39:0] pin_out,
	input wire logic [39:0] pin_oe,
	input wire logic [39:0] periph_out_sel,
	input wire logic [39:0] periph_out
);
	localparam logic [39:0] DRV = 40'h03_ff02_5fff;
	logic rd_take;
	logic wr_take;
	logic [7:0] rmask;
	assign rd_take = hsel && htrans[1] && hready && !hwrite;
	assign wr_take = hsel && htrans[1] && hready && hwrite;
	always_comb begin
		case (haddr[11:2])
			`BPB_IDX_P5_DATA: rmask = 8'h7f;
			`BPB_IDX_P5_DIR: rmask = 8'h5f;
			`BPB_IDX_P7_DATA, `BPB_IDX_P7_DIR: rmask = 8'h02;
			`BPB_IDX_P9_DATA, `BPB_IDX_P9_DIR: rmask = 8'h03;
			default: rmask = 8'hff;
		endcase
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	never_drive_a: assert property ((pin_oe & ~DRV) == 40'h00_0000_0000)
		else $error("pin without driver enabled");
	periph_oe_a: assert property ($past(hresetn) |->
		(pin_oe & $past(periph_out_sel) & DRV) == ($past(periph_out_sel) & DRV))
		else $error("owned pin not enabled");
	periph_out_a: assert property ($past(hresetn) |->
		((pin_out ^ $past(periph_out)) & $past(periph_out_sel) & DRV) == 40'h00_0000_0000)
		else $error("owned pin value wrong");
	rsvd_read_a: assert property (rd_take |-> ##2
		(hrdata & ~{24'h00_0000, $past(rmask, 2)}) == 32'h0000_0000)
		else $error("reserved bits read nonzero");
	read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_ready_a: assert property (wr_take |=> hreadyout)
		else $error("write stalled");
	resp_okay_a: assert property (hresp == 1'h0)
		else $error("response not okay");
	pins_quiet_a: assert property ($past(hresetn) && $past(hresetn, 2) && $past(hresetn, 3)
		&& !$past(wr_take, 3) && $past(periph_out_sel) == $past(periph_out_sel, 2)
		&& $past(periph_out) == $past(periph_out, 2) |-> $stable(pin_oe) && $stable(pin_out))
		else $error("pins changed without cause");
endmodule // bpb_top_asserts
bind bpb_top bpb_top_asserts i_bpb_top_asserts (.*);

/* test/tb.sv */
`timescale 1ns/1ns
`include "bpb_regs.svh"
module tb;
	localparam logic [39:0] DRV = 40'h03_ff02_5fff;
	logic hclk = 1'h0;
	logic hresetn = 1'h0;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic hready, hreadyout, hresp;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata, r;
	logic [39:0] ext = 40'h5a_963c_a5c3;
	logic [39:0] periph_out_sel = 40'h00_0000_0000;
	logic [39:0] periph_out = 40'h00_0000_0000;
	logic [39:0] pin_in, pin_out, pin_oe;
	logic [9:0] di[5] = '{`BPB_IDX_P2_DATA, `BPB_IDX_P5_DATA, `BPB_IDX_P7_DATA,
		`BPB_IDX_P8_DATA, `BPB_IDX_P9_DATA};
	logic [9:0] dx[5] = '{`BPB_IDX_P2_DIR, `BPB_IDX_P5_DIR, `BPB_IDX_P7_DIR,
		`BPB_IDX_P8_DIR, `BPB_IDX_P9_DIR};
	logic [7:0] dm[5] = '{8'hff, 8'h7f, 8'h02, 8'hff, 8'h03};
	logic [7:0] rm[5] = '{8'hff, 8'h5f, 8'h02, 8'hff, 8'h03};
	int miscompares = 0;
	int num_checks = 0;
	assign hready = hreadyout;
	bpb_top i_bpb_top (.*);
	bpb_pin_env i_bpb_pin_env (.*);
	always #50 hclk = ~hclk;
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] ix, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0_0000, ix, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		do @(posedge hclk); while (hreadyout !== 1'h1);
		r = hrdata;
	endtask
	task automatic rd(input logic [9:0] ix, input logic [7:0] e);
		bus(1'h0, ix, 8'h00);
		chk({8'h00, r}, {32'h0000_0000, e});
	endtask
	task automatic pins(input logic [39:0] oe, input logic [39:0] out);
		repeat (2) @(posedge hclk);
		chk(pin_oe, oe);
		chk(pin_out & oe, out);
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge hclk);
		miscompares++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		for (int i = 0; i < 5; i++) begin
			rd(dx[i], 8'h00);
			rd(di[i], ext[i*8+:8] & dm[i]);
		end
		for (int i = 0; i < 5; i++) begin
			bus(1'h1, dx[i], 8'hff);
			bus(1'h1, di[i], 8'hff);
			rd(dx[i], rm[i]);
			rd(di[i], dm[i] & (rm[i] | ext[i*8+:8]));
		end
		pins(DRV, DRV);
		bus(1'h1, dx[0], 8'h00);
		bus(1'h1, di[0], 8'h3c);
		rd(di[0], 8'hc3);
		bus(1'h1, dx[0], 8'h0f);
		pins(DRV & 40'hff_ffff_ff0f, DRV & 40'hff_ffff_ff0c);
		rd(di[0], 8'hcc);
		periph_out_sel <= 40'hff_ffff_ffff;
		periph_out <= 40'h96_a53c_5a69;
		pins(DRV, 40'h96_a53c_5a69 & DRV);
		rd(di[0], 8'h6c);
		bus(1'h1, dx[0], 8'hff);
		pins(DRV, 40'h96_a53c_5a69 & DRV);
		rd(di[0], 8'h3c);
		bus(1'h1, 10'h000, 8'hff);
		rd(10'h000, 8'h00);
		@(posedge hclk);
		hresetn <= 1'h0;
		periph_out_sel <= 40'h00_0000_0000;
		pins(40'h00_0000_0000, 40'h00_0000_0000);
		chk(pin_out, 40'h00_0000_0000);
		hresetn <= 1'h1;
		rd(dx[0], 8'h00);
		wrap_up();
	end
endmodule // tb
